// ---- include/clkgen_pkg.sv ----
package clkgen_pkg;

	// register field layout
	localparam int DIV_FIELD_LSB = 0;
	localparam int DIV_FIELD_MSB = 2;
	localparam int REDUCED_BIT_POS = 7;

	// reset values
	localparam logic [7:0] DIVIDER_RESET = 8'h04;
	localparam logic [7:0] OSC_MODE_RESET = 8'h00;

	// divider codes
	localparam logic [2:0] DIV_FULL = 3'h0;
	localparam logic [2:0] DIV_SLOWEST = 3'h4;

	// cycles of the old cpu clock per minimum instruction
	localparam logic [4:0] CLOCKS_PER_INSTR = 5'h02;

	// delay in instructions from the fastest setting; halves per step
	localparam logic [4:0] SWITCH_INSTR_FAST = 5'h10;

	// oscillator stabilisation, in main clock periods (2^17)
	localparam int STAB_PERIODS = 131072;

	// sequencer states, one-hot
	typedef enum logic [2:0] {
		ST_OSC_STOP = 3'h1,
		ST_STABILISE = 3'h2,
		ST_RUN = 3'h4
	} seq_state_t;

	// software access to the two control registers
	typedef struct packed {
		logic       div_we;
		logic       osc_we;
		logic [7:0] wdata;
	} reg_write_t;

	// all block state except the reset pin synchroniser
	typedef struct packed {
		seq_state_t  state;
		logic [17:0] stab_cnt;
		logic [7:0]  div_reg;
		logic [2:0]  active_sel;
		logic        switch_pend;
		logic [4:0]  instr_left;
		logic [4:0]  clk_in_instr;
		logic [3:0]  prescale;
		logic        osc_reduced;
		logic        osc_written;
		logic        osc_run;
		logic        cpu_reset;
		logic        cpu_en;
		logic        periph_en;
		logic        stop_ack;
		logic        halt_ack;
	} clkgen_state_t;

endpackage

// ---- logic/cpu_clock_generator_control.sv ----
`timescale 1ns/1ps
module cpu_clock_generator_control
(
	// clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 reset,
	// reset pin from outside, active low
	input  wire logic                 reset_pin_n,
	// register writes and standby requests from the cpu core
	input  wire clkgen_pkg::reg_write_t reg_wr,
	input  wire logic                 stop_req,
	input  wire logic                 halt_req,
	input  wire logic                 wake_req,
	// register read-back
	output logic [7:0]                div_rdata,
	output logic [7:0]                osc_rdata,
	// clock enables of the main clock, with prescaler, reset and status outputs
	output logic                      osc_running,
	output logic                      cpu_clk_en,
	output logic                      periph_clk_en,
	output logic [3:0]                periph_prescale,
	output logic                      cpu_reset_out,
	output logic                      reduced_current,
	output logic [2:0]                active_ratio,
	output logic                      switch_pending,
	output logic                      stop_active,
	output logic                      halt_active
);

	// two-stage synchroniser for the reset pin
	logic pin_meta_reg;
	logic pin_sync_reg;
	clkgen_pkg::clkgen_state_t st_reg;
	clkgen_pkg::clkgen_state_t st_next;

	// divide mask for code n: clock enable when low n bits of prescale all 1
	function automatic logic tick_for(input logic [2:0] sel,
		input logic [3:0] pre);
		logic [3:0] mask;
		mask = 4'hf >> (3'h4 - sel);
		tick_for = ((pre & mask) == mask);
	endfunction

	// delay in instructions for an old code
	function automatic logic [4:0] delay_for(input logic [2:0] sel);
		delay_for = clkgen_pkg::SWITCH_INSTR_FAST >> sel;
	endfunction

	// code is one of the five legal settings
	function automatic logic legal(input logic [2:0] sel);
		legal = (sel <= clkgen_pkg::DIV_SLOWEST);
	endfunction

	// reset pin synchroniser
	always_ff @(posedge sys_clk)
	begin
		pin_meta_reg <= reset_pin_n;
		pin_sync_reg <= pin_meta_reg;
	end

	// next-state logic
	always_comb
	begin
		logic tick;
		logic instr_end;
		tick = 1'b0;
		instr_end = 1'b0;
		st_next = st_reg;
		st_next.cpu_en = 1'b0;
		st_next.periph_en = 1'b0;

		// main clock prescaler runs only while oscillating
		if (st_reg.osc_run)
		begin
			st_next.prescale = st_reg.prescale + 4'h1;
			tick = tick_for(st_reg.active_sel, st_reg.prescale);
		end
		else
			st_next.prescale = 4'h0;

		unique case (st_reg.state)
			clkgen_pkg::ST_OSC_STOP:
			begin
				st_next.osc_run = 1'b0;
				st_next.cpu_reset = 1'b1;
				if (pin_sync_reg)
				begin
					st_next.state = clkgen_pkg::ST_STABILISE;
					st_next.osc_run = 1'b1;
					st_next.stab_cnt = 18'h0;
				end
			end
			clkgen_pkg::ST_STABILISE:
			begin
				st_next.stab_cnt = st_reg.stab_cnt + 18'h1;
				if (st_reg.stab_cnt ==
					18'(clkgen_pkg::STAB_PERIODS - 1))
				begin
					st_next.state = clkgen_pkg::ST_RUN;
					st_next.cpu_reset = 1'b0;
				end
			end
			clkgen_pkg::ST_RUN:
			begin
				// stop and halt standby, wake by request
				if (stop_req && !st_reg.halt_ack)
				begin
					st_next.stop_ack = 1'b1;
					st_next.osc_run = 1'b0;
				end
				else if (halt_req && !st_reg.stop_ack)
					st_next.halt_ack = 1'b1;
				if (wake_req && (st_reg.stop_ack || st_reg.halt_ack))
				begin
					st_next.stop_ack = 1'b0;
					st_next.halt_ack = 1'b0;
					st_next.osc_run = 1'b1;
				end
				if (tick && st_reg.osc_run)
				begin
					st_next.cpu_en = !st_reg.halt_ack;
					// peripherals follow the divided clock tick, not gated by halt
					st_next.periph_en = 1'b1;
					// count old-clock cycles into instructions
					if (st_reg.clk_in_instr ==
						clkgen_pkg::CLOCKS_PER_INSTR - 5'h1)
					begin
						st_next.clk_in_instr = 5'h0;
						instr_end = 1'b1;
					end
					else
						st_next.clk_in_instr =
							st_reg.clk_in_instr + 5'h1;
				end
				// pending switch applied at an instruction boundary
				if (st_reg.switch_pend && instr_end)
				begin
					if (st_reg.instr_left <= 5'h1)
					begin
						st_next.active_sel =
							st_reg.div_reg[2:0];
						st_next.switch_pend = 1'b0;
						st_next.prescale = 4'h0;
					end
					else
						st_next.instr_left =
							st_reg.instr_left - 5'h1;
				end
			end
			default:
				st_next.state = clkgen_pkg::ST_OSC_STOP;
		endcase

		// divider register write, prohibited codes dropped
		if (reg_wr.div_we && legal(reg_wr.wdata[2:0]))
		begin
			st_next.div_reg = {5'h0, reg_wr.wdata[2:0]};
			if (reg_wr.wdata[2:0] != st_reg.active_sel)
			begin
				st_next.switch_pend = 1'b1;
				st_next.instr_left =
					delay_for(st_reg.active_sel);
			end
			else
				st_next.switch_pend = 1'b0;
		end

		// oscillator mode register, first write only
		if (reg_wr.osc_we && !st_reg.osc_written)
		begin
			st_next.osc_written = 1'b1;
			st_next.osc_reduced =
				reg_wr.wdata[clkgen_pkg::REDUCED_BIT_POS];
		end

		// reset pin low forces the stopped state
		if (!pin_sync_reg)
		begin
			st_next.state = clkgen_pkg::ST_OSC_STOP;
			st_next.osc_run = 1'b0;
			st_next.cpu_reset = 1'b1;
			st_next.cpu_en = 1'b0;
			st_next.periph_en = 1'b0;
			st_next.div_reg = clkgen_pkg::DIVIDER_RESET;
			st_next.active_sel = clkgen_pkg::DIV_SLOWEST;
			st_next.switch_pend = 1'b0;
			st_next.stop_ack = 1'b0;
			st_next.halt_ack = 1'b0;
			st_next.clk_in_instr = 5'h0;
			// a pin reset re-arms the write-once mode register
			st_next.osc_written = 1'b0;
			st_next.osc_reduced =
				clkgen_pkg::OSC_MODE_RESET[clkgen_pkg::REDUCED_BIT_POS];
		end
	end

	// state register
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			st_reg <= '0;
			st_reg.state <= clkgen_pkg::ST_OSC_STOP;
			st_reg.div_reg <= clkgen_pkg::DIVIDER_RESET;
			st_reg.active_sel <= clkgen_pkg::DIV_SLOWEST;
			st_reg.osc_reduced <= clkgen_pkg::OSC_MODE_RESET[7];
			st_reg.cpu_reset <= 1'b1;
		end
		else
			st_reg <= st_next;
	end

	// outputs straight from the state register
	assign div_rdata = st_reg.div_reg;
	assign osc_rdata = {st_reg.osc_reduced, 7'h0};
	assign osc_running = st_reg.osc_run;
	assign cpu_clk_en = st_reg.cpu_en;
	assign periph_clk_en = st_reg.periph_en;
	assign periph_prescale = st_reg.prescale;
	assign cpu_reset_out = st_reg.cpu_reset;
	assign reduced_current = st_reg.osc_reduced;
	assign active_ratio = st_reg.active_sel;
	assign switch_pending = st_reg.switch_pend;
	assign stop_active = st_reg.stop_ack;
	assign halt_active = st_reg.halt_ack;

endmodule

// ---- test/clkgen_chk.sv ----
`timescale 1ns/1ps
module clkgen_chk
(
	// clock and reset
	input wire logic                   sys_clk,
	input wire logic                   reset,
	input wire logic                   reset_pin_n,
	// register side
	input wire clkgen_pkg::reg_write_t reg_wr,
	input wire logic [7:0]             div_rdata,
	input wire logic [7:0]             osc_rdata,
	// clock side
	input wire logic                   osc_running,
	input wire logic                   cpu_reset_out,
	input wire logic [2:0]             active_ratio,
	input wire logic                   switch_pending
);
	logic seen_reg;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// remembers that the mode register took its first write
	always_ff @(posedge sys_clk)
		seen_reg <= !reset && (seen_reg || reg_wr.osc_we);
	// divider and cpu hold after reset
	property p_rst; $past(reset) |-> div_rdata == 8'h04 && cpu_reset_out;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	property p_pin; !reset_pin_n [*4] |-> !osc_running && cpu_reset_out;
	endproperty
	a_pin: assert property (p_pin) else $error("pin hold");
	// divider writes: legal codes land, others dropped
	property p_div; reg_wr.div_we && reg_wr.wdata[2:0] < 3'h5
		|=> div_rdata == {5'h00, $past(reg_wr.wdata[2:0])}; endproperty
	a_div: assert property (p_div) else $error("div write");
	property p_bad; reg_wr.div_we && reg_wr.wdata[2:0] > 3'h4
		|=> $stable(div_rdata); endproperty
	a_bad: assert property (p_bad) else $error("bad code");
	// mode register takes its first write only
	property p_osc; reg_wr.osc_we && !seen_reg
		|=> osc_rdata == {$past(reg_wr.wdata[7]), 7'h00}; endproperty
	a_osc: assert property (p_osc) else $error("osc write");
	property p_once; reg_wr.osc_we && seen_reg |=> $stable(osc_rdata);
	endproperty
	a_once: assert property (p_once) else $error("osc rewrite");
	// switch ends within the old-clock delay, ratio kept meanwhile
	property p_pend; $rose(switch_pending) |-> ##[1:48] !switch_pending;
	endproperty
	a_pend: assert property (p_pend) else $error("switch long");
	property p_keep; switch_pending |=> $stable(active_ratio)
		|| !switch_pending; endproperty
	a_keep: assert property (p_keep) else $error("early ratio");
	c_sw: cover property ($fell(switch_pending));
	c_once: cover property (reg_wr.osc_we && seen_reg);
	c_run: cover property ($fell(cpu_reset_out));
endmodule
bind cpu_clock_generator_control clkgen_chk u_clkgen_chk (.*);

// ---- test/cpu_core_model.sv ----
`timescale 1ns/1ps
module cpu_core_model
(
	// clock
	input wire logic              sys_clk,
	// requests to the clock generator
	output clkgen_pkg::reg_write_t reg_wr,
	output logic                  stop_req
);
	// idle requests from time zero
	initial
	begin
		reg_wr = '0;
		stop_req = 1'b0;
	end
	// one register write held for a single edge
	task automatic wr(input logic osc, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= '{div_we: !osc, osc_we: osc, wdata: d};
		@(posedge sys_clk);
		reg_wr <= '0;
	endtask
	// standby entry, one cycle pulse
	task automatic stop;
		@(posedge sys_clk);
		stop_req <= 1'b1;
		@(posedge sys_clk);
		stop_req <= 1'b0;
	endtask
endmodule

// ---- test/cpu_clock_generator_control_tb_top.sv ----
`timescale 1ns/1ps
module cpu_clock_generator_control_tb_top;
	logic                   sys_clk = 1'b0;
	logic                   reset = 1'b1;
	logic                   reset_pin_n = 1'b0;
	clkgen_pkg::reg_write_t reg_wr;
	logic                   stop_req;
	logic [7:0]             div_rdata;
	logic [7:0]             osc_rdata;
	logic                   osc_running;
	logic                   cpu_clk_en;
	logic                   periph_clk_en;
	logic                   reduced_current;
	logic                   stop_active;
	logic                   cpu_reset_out;
	logic [2:0]             active_ratio;
	logic                   switch_pending;
	int                     err_total = 0;
	int                     n_compared = 0;
	int                     n;
	int                     cyc = 0;
	int                     t0;
	// clock and cycle count
	always #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) cyc++;
	cpu_core_model u_cpu_core_model (.sys_clk(sys_clk), .reg_wr(reg_wr),
		.stop_req(stop_req));
	cpu_clock_generator_control u_cpu_clock_generator_control (
		.sys_clk(sys_clk), .reset(reset), .reset_pin_n(reset_pin_n),
		.reg_wr(reg_wr), .stop_req(stop_req), .halt_req(1'b0),
		.wake_req(1'b0), .div_rdata(div_rdata), .osc_rdata(osc_rdata),
		.osc_running(osc_running), .cpu_clk_en(cpu_clk_en),
		.periph_clk_en(periph_clk_en), .periph_prescale(),
		.cpu_reset_out(cpu_reset_out),
		.reduced_current(reduced_current), .active_ratio(active_ratio),
		.switch_pending(switch_pending), .stop_active(stop_active),
		.halt_active());
	task automatic chk(input logic ok, input string m);
		n_compared++;
		if (ok !== 1'b1)
			$display("mismatch at %0t: %s", $time, m);
		if (ok !== 1'b1)
			err_total++;
	endtask
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// one ratio change: read-back, delay, new cpu clock spacing
	task automatic t_switch(input logic [2:0] c);
		logic [2:0] o;
		int         lo;
		// old ratio sets the delay: at most 32 cycles, at least one instr less
		o = active_ratio;
		lo = 33 - (2 << o);
		u_cpu_core_model.wr(1'b0, {5'h00, c});
		@(negedge sys_clk);
		chk(div_rdata === {5'h00, c} && switch_pending === 1'b1, "wr");
		for (n = 0; switch_pending === 1'b1 && n < 60; n++) @(negedge sys_clk);
		chk(n >= lo && n <= 32 && active_ratio === c, "delay");
		for (n = 0; cpu_clk_en !== 1'b1 && n < 40; n++) @(negedge sys_clk);
		n = 0;
		do
		begin
			@(negedge sys_clk);
			n++;
		end while (cpu_clk_en !== 1'b1 && n < 40);
		chk(n == (1 << c), "cpu rate");
	endtask
	// main sequence
	initial
	begin
		repeat (4) @(posedge sys_clk);
		reset <= 1'b0;
		repeat (4) @(negedge sys_clk);
		chk(div_rdata === 8'h04 && osc_rdata === 8'h00, "rst");
		chk(osc_running === 1'b0 && cpu_reset_out === 1'b1, "pin");
		@(posedge sys_clk);
		reset_pin_n <= 1'b1;
		t0 = cyc;
		repeat (4) @(posedge sys_clk);
		u_cpu_core_model.wr(1'b0, 8'h07);
		@(negedge sys_clk);
		chk(div_rdata === 8'h04, "bad code");
		u_cpu_core_model.wr(1'b1, 8'h80);
		@(negedge sys_clk);
		chk(osc_rdata === 8'h80 && reduced_current === 1'b1, "osc");
		u_cpu_core_model.wr(1'b1, 8'h00);
		@(negedge sys_clk);
		chk(osc_rdata === 8'h80, "osc once");
		for (n = 0; cpu_reset_out !== 1'b0 && n < 140000; n++) @(negedge sys_clk);
		n = cyc - t0;
		chk(n >= 131072 && n <= 131080 && active_ratio === 3'h4, "stab");
		for (int c = 0; c < 5; c++) t_switch(c[2:0]);
		u_cpu_core_model.stop();
		repeat (4) @(negedge sys_clk);
		chk(osc_running === 1'b0 && stop_active === 1'b1, "stop");
		chk(periph_clk_en === 1'b0, "periph stop");
		test_done();
	end
	// hang guard
	initial
	begin
		#(140000 * 50);
		err_total++;
		test_done();
	end
endmodule
